// [pfsa_map.svh]
// Offsets, field positions, reset values and timing counts of the flash access block
`ifndef PFSA_MAP_SVH
`define PFSA_MAP_SVH

// ********************
// Register selects
// ********************
`define PFSA_SEL_ADDR_LOW 3'h0
`define PFSA_SEL_ADDR_HIGH 3'h1
`define PFSA_SEL_DATA_LOW 3'h2
`define PFSA_SEL_DATA_HIGH 3'h3
`define PFSA_SEL_CONTROL 3'h4
`define PFSA_SEL_UNLOCK 3'h5

// ********************
// Control register bit positions
// ********************
`define PFSA_CTL_RD 0
`define PFSA_CTL_WR 1
`define PFSA_CTL_WRITE_ENABLE_BIT 2
`define PFSA_CTL_WRITE_ERROR_FLAG 3
`define PFSA_CTL_FREE 4
`define PFSA_CTL_LWLO 5

// ********************
// Widths, reset values and unlock pattern
// ********************
`define PFSA_ADDR_W 15
`define PFSA_DATA_W 14
`define PFSA_ROW_WORDS 32
`define PFSA_ADDR_RESET 15'h0000
`define PFSA_DATA_RESET 14'h0000
`define PFSA_UNLOCK_KEY1 8'h55
`define PFSA_UNLOCK_KEY2 8'hAA
`define PFSA_WP_LIMIT_BOOT 15'h0200
`define PFSA_WP_LIMIT_HALF 15'h4000

// ********************
// Timing
// ********************
`define PFSA_CLK_PERIOD_NS 50
`define PFSA_PROG_TIME_NS 2000
`define PFSA_ERASE_TIME_NS 2000
`define PFSA_PROG_CYCLES \
    ((`PFSA_PROG_TIME_NS + `PFSA_CLK_PERIOD_NS - 1) / `PFSA_CLK_PERIOD_NS)
`define PFSA_ERASE_CYCLES \
    ((`PFSA_ERASE_TIME_NS + `PFSA_CLK_PERIOD_NS - 1) / `PFSA_CLK_PERIOD_NS)

`endif

// [pfsa_pkg.sv]
// Types shared by the flash access block
package pfsa_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RD_WAIT,
        ST_RD_CAP,
        ST_IND_WAIT,
        ST_IND_CAP,
        ST_LOAD,
        ST_PROG,
        ST_ERASE
    } pfsa_state_type;

    typedef enum logic [1:0] {
        UNL_NONE,
        UNL_FIRST,
        UNL_ARMED
    } pfsa_unlock_type;

    typedef struct packed {
        logic lwlo;
        logic free;
        logic write_error_flag;
        logic write_enable_bit;
        logic wr;
        logic rd;
    } pfsa_ctrl_type;

    typedef struct packed {
        logic rd;
        logic load;
        logic prog;
        logic erase;
        logic bulk;
        logic [14:0] addr;
        logic [13:0] wdata;
    } pfsa_flash_cmd_type;

endpackage

// [pfsa_sync.sv]
// Two-stage synchroniser for asynchronous level inputs
`timescale 1ns/1ns
`default_nettype none

module pfsa_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_clock,
    input wire logic i_arst_n,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // First stage feeds only the second stage
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
        end
        else
        begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
        end
    end

    assign o_sync = sync_reg;

endmodule

`default_nettype wire

// [pfsa_top.sv]
// Program flash self-access sequencer with indirect read path
//
// Behaviour
// - Data pair holds 14-bit flash word
// - Address pair forms 15-bit word address
// - Address reaches any of 32K words
// - Internal timer times program and erase
// - Code lock blocks programmer, not self-write
// - Only programmer bulk erase releases lock
// - Protected region refuses self-write and erase
// - Read/write start bits set-only, hardware cleared
// - Writes need write enable; cleared at power-up
// - Reset during write sets error flag
// - Unlock register reads as zero
// - Writes blocked until unlock pattern written
// - Pointer top bit maps flash, low byte
// - Indirect flash path is read-only
// - Indirect flash read stalls for two cycles
// - Latches filled word by word, indexed by address low bits
// - Erase removes one whole row
`timescale 1ns/1ns
`default_nettype none
`include "pfsa_map.svh"

module pfsa_top
    import pfsa_pkg::*;
(
    input wire logic I_CLOCK,
    input wire logic I_ARST_N,
    input wire logic I_POR_N,
    input wire logic I_REG_WR,
    input wire logic [2:0] I_REG_SEL,
    input wire logic [7:0] I_REG_WDATA,
    output logic [7:0] O_REG_RDATA,
    input wire logic I_IND_RD,
    input wire logic [15:0] I_IND_ADDR,
    output logic [7:0] O_IND_RDATA,
    output logic O_IND_VALID,
    output logic O_IND_STALL,
    output pfsa_flash_cmd_type O_FLASH_CMD,
    input wire logic [13:0] I_FLASH_RDATA,
    input wire logic I_CFG_CODE_PROTECT_N,
    input wire logic [1:0] I_CFG_WRITE_PROTECT,
    input wire logic I_PGM_RD_REQ,
    input wire logic I_PGM_WR_REQ,
    input wire logic I_PGM_BULK_ERASE,
    output logic O_PGM_RD_GRANT,
    output logic O_PGM_WR_GRANT,
    output logic O_CODE_LOCKED,
    output logic O_WP_REFUSED,
    output logic O_BUSY
);

    // ********************
    // Declarations
    // ********************
    logic rst_n;
    pfsa_state_type state_reg, state_next;
    pfsa_unlock_type unlock_reg, unlock_next;
    pfsa_ctrl_type ctrl_reg, ctrl_next;
    pfsa_flash_cmd_type flash_reg, flash_next;
    logic [14:0] addr_reg, addr_next;
    logic [13:0] data_reg, data_next;
    logic [4:0] idx_reg, idx_next;
    logic [7:0] timer_reg, timer_next;
    logic [7:0] rdata_reg, rdata_next;
    logic [7:0] ind_rdata_reg, ind_rdata_next;
    logic ind_valid_reg, ind_valid_next;
    logic stall_reg, stall_next;
    logic refused_reg, refused_next;
    logic busy_reg, busy_next;
    logic mark_reg, mark_next;
    logic cp_reg, cp_next;
    logic cp_loaded_reg, cp_loaded_next;
    logic bulk_prev_reg, bulk_prev_next;
    logic pgm_rd_reg, pgm_rd_next;
    logic pgm_wr_reg, pgm_wr_next;
    logic [2:0] pgm_sync;
    logic bulk_edge;
    logic wr_go;
    logic latch_we;
    logic [13:0] latch_mem [0:`PFSA_ROW_WORDS-1];

    // Power-up also clears everything the device reset clears
    assign rst_n = I_ARST_N & I_POR_N;

    // Programmer pins come from outside the clock domain
    pfsa_sync #(
        .WIDTH(3)
    ) u_pgm_sync (
        .i_clock(I_CLOCK),
        .i_arst_n(rst_n),
        .i_async({I_PGM_BULK_ERASE, I_PGM_WR_REQ, I_PGM_RD_REQ}),
        .o_sync(pgm_sync)
    );

    // Write-protect region lookup
    function automatic logic wp_hit(input logic [1:0] cfg,
                                    input logic [14:0] a);
        logic hit;
        hit = 1'b0;
        case (cfg)
            2'b00: hit = 1'b1;
            2'b01: hit = (a < `PFSA_WP_LIMIT_HALF);
            2'b10: hit = (a < `PFSA_WP_LIMIT_BOOT);
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    // ********************
    // Sequencer and register file
    // ********************
    // Start is accepted only right after the two keys
    always_comb
    begin
        wr_go = I_REG_WR && (I_REG_SEL == `PFSA_SEL_CONTROL) &&
            I_REG_WDATA[`PFSA_CTL_WR] && (unlock_reg == UNL_ARMED);
    end

    // Next state of the sequencer and software-visible registers
    always_comb
    begin
        state_next = state_reg;
        unlock_next = unlock_reg;
        ctrl_next = ctrl_reg;
        addr_next = addr_reg;
        data_next = data_reg;
        idx_next = idx_reg;
        timer_next = timer_reg;
        flash_next = flash_reg;
        flash_next.rd = 1'b0;
        flash_next.load = 1'b0;
        flash_next.prog = 1'b0;
        flash_next.erase = 1'b0;
        ind_rdata_next = ind_rdata_reg;
        ind_valid_next = 1'b0;
        stall_next = stall_reg;
        refused_next = 1'b0;
        latch_we = 1'b0;
        mark_next = mark_reg;

        if (I_REG_WR)
        begin
            if (I_REG_SEL == `PFSA_SEL_UNLOCK)
            begin
                if (I_REG_WDATA == `PFSA_UNLOCK_KEY1)
                    unlock_next = UNL_FIRST;
                else if (I_REG_WDATA == `PFSA_UNLOCK_KEY2 &&
                         unlock_reg == UNL_FIRST)
                    unlock_next = UNL_ARMED;
                else
                    unlock_next = UNL_NONE;
            end
            else
                unlock_next = UNL_NONE;
        end

        if (I_REG_WR)
        begin
            if (I_REG_SEL == `PFSA_SEL_ADDR_LOW)
                addr_next[7:0] = I_REG_WDATA;
            else if (I_REG_SEL == `PFSA_SEL_ADDR_HIGH)
                addr_next[14:8] = I_REG_WDATA[6:0];
            else if (I_REG_SEL == `PFSA_SEL_DATA_LOW)
                data_next[7:0] = I_REG_WDATA;
            else if (I_REG_SEL == `PFSA_SEL_DATA_HIGH)
                data_next[13:8] = I_REG_WDATA[5:0];
            else if (I_REG_SEL == `PFSA_SEL_CONTROL)
            begin
                // start bits only set by software
                ctrl_next.rd = ctrl_reg.rd | I_REG_WDATA[`PFSA_CTL_RD];
                // and the enable in the same write
                ctrl_next.wr = ctrl_reg.wr |
                    (wr_go & I_REG_WDATA[`PFSA_CTL_WRITE_ENABLE_BIT]);
                ctrl_next.write_enable_bit = I_REG_WDATA[`PFSA_CTL_WRITE_ENABLE_BIT];
                ctrl_next.write_error_flag = I_REG_WDATA[`PFSA_CTL_WRITE_ERROR_FLAG];
                ctrl_next.free = I_REG_WDATA[`PFSA_CTL_FREE];
                ctrl_next.lwlo = I_REG_WDATA[`PFSA_CTL_LWLO];
            end
        end

        case (state_reg)
            ST_IDLE:
            begin
                if (ctrl_reg.wr)
                begin
                    if (ctrl_reg.lwlo)
                    begin
                        // load one hidden latch per start
                        latch_we = 1'b1;
                        ctrl_next.wr = 1'b0;
                    end
                    else if (wp_hit(I_CFG_WRITE_PROTECT, addr_reg))
                    begin
                        refused_next = 1'b1;
                        ctrl_next.wr = 1'b0;
                    end
                    else if (ctrl_reg.free)
                    begin
                        // erase whole row at row base
                        flash_next.addr = {addr_reg[14:5], 5'h00};
                        flash_next.erase = 1'b1;
                        timer_next = 8'(`PFSA_ERASE_CYCLES - 1);
                        mark_next = 1'b1;
                        state_next = ST_ERASE;
                    end
                    else
                    begin
                        idx_next = 5'h00;
                        mark_next = 1'b1;
                        state_next = ST_LOAD;
                    end
                end
                else if (ctrl_reg.rd)
                begin
                    flash_next.addr = addr_reg;
                    flash_next.rd = 1'b1;
                    state_next = ST_RD_WAIT;
                end
                else if (I_IND_RD && I_IND_ADDR[15])
                begin
                    flash_next.addr = I_IND_ADDR[14:0];
                    flash_next.rd = 1'b1;
                    stall_next = 1'b1;
                    state_next = ST_IND_WAIT;
                end
            end
            ST_RD_WAIT:
                state_next = ST_RD_CAP;
            ST_RD_CAP:
            begin
                // full 14-bit word into data pair
                data_next = I_FLASH_RDATA;
                ctrl_next.rd = 1'b0;
                state_next = ST_IDLE;
            end
            ST_IND_WAIT:
                state_next = ST_IND_CAP;
            ST_IND_CAP:
            begin
                ind_rdata_next = I_FLASH_RDATA[7:0];
                ind_valid_next = 1'b1;
                stall_next = 1'b0;
                state_next = ST_IDLE;
            end
            ST_LOAD:
            begin
                flash_next.addr = {addr_reg[14:5], idx_reg};
                flash_next.wdata = latch_mem[idx_reg];
                flash_next.load = 1'b1;
                idx_next = idx_reg + 5'h01;
                if (idx_reg == 5'h1F)
                begin
                    timer_next = 8'(`PFSA_PROG_CYCLES);
                    state_next = ST_PROG;
                end
            end
            ST_PROG, ST_ERASE:
            begin
                if (timer_reg != 8'h00)
                begin
                    timer_next = timer_reg - 8'h01;
                    flash_next.prog = (state_reg == ST_PROG);
                    flash_next.erase = (state_reg == ST_ERASE);
                end
                else
                begin
                    ctrl_next.wr = 1'b0;
                    mark_next = 1'b0;
                    state_next = ST_IDLE;
                end
            end
            default:
                state_next = ST_IDLE;
        endcase

        // mark survives reset; set beats clear
        if (mark_reg && state_reg == ST_IDLE && rst_n)
        begin
            ctrl_next.write_error_flag = 1'b1;
            mark_next = 1'b0;
        end

        // bulk erase always passes to flash
        flash_next.bulk = bulk_edge;
    end

    // Readback, one cycle after the select
    always_comb
    begin
        rdata_next = 8'h00;
        if (I_REG_SEL == `PFSA_SEL_ADDR_LOW)
            rdata_next = addr_reg[7:0];
        else if (I_REG_SEL == `PFSA_SEL_ADDR_HIGH)
            rdata_next = {1'b0, addr_reg[14:8]};
        else if (I_REG_SEL == `PFSA_SEL_DATA_LOW)
            rdata_next = data_reg[7:0];
        else if (I_REG_SEL == `PFSA_SEL_DATA_HIGH)
            rdata_next = {2'b00, data_reg[13:8]};
        else if (I_REG_SEL == `PFSA_SEL_CONTROL)
            rdata_next = {2'b00, ctrl_reg.lwlo, ctrl_reg.free,
                ctrl_reg.write_error_flag, ctrl_reg.write_enable_bit, ctrl_reg.wr, ctrl_reg.rd};
        // unlock select falls through to zero
        busy_next = (state_reg != ST_IDLE) | ctrl_reg.wr | ctrl_reg.rd;
    end

    // Sequencer registers
    always_ff @(posedge I_CLOCK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= ST_IDLE;
            unlock_reg <= UNL_NONE;
            ctrl_reg <= '0;
            flash_reg <= '0;
            addr_reg <= `PFSA_ADDR_RESET;
            data_reg <= `PFSA_DATA_RESET;
            idx_reg <= 5'h00;
            timer_reg <= 8'h00;
            rdata_reg <= 8'h00;
            ind_rdata_reg <= 8'h00;
            ind_valid_reg <= 1'b0;
            stall_reg <= 1'b0;
            refused_reg <= 1'b0;
            busy_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            unlock_reg <= unlock_next;
            ctrl_reg <= ctrl_next;
            flash_reg <= flash_next;
            addr_reg <= addr_next;
            data_reg <= data_next;
            idx_reg <= idx_next;
            timer_reg <= timer_next;
            rdata_reg <= rdata_next;
            ind_rdata_reg <= ind_rdata_next;
            ind_valid_reg <= ind_valid_next;
            stall_reg <= stall_next;
            refused_reg <= refused_next;
            busy_reg <= busy_next;
        end
    end

    // Write-in-progress mark, reset only by power-up
    always_ff @(posedge I_CLOCK or negedge I_POR_N)
    begin
        if (!I_POR_N)
            mark_reg <= 1'b0;
        else
            mark_reg <= mark_next;
    end

    // Hidden row latches, no reset needed for data storage
    always_ff @(posedge I_CLOCK)
    begin
        if (latch_we)
            latch_mem[addr_reg[4:0]] <= data_reg;
    end

    // ********************
    // Code protection and programmer access
    // ********************
    // Lock strap caught on first edge after reset release
    always_comb
    begin
        bulk_edge = pgm_sync[2] & ~bulk_prev_reg;
        bulk_prev_next = pgm_sync[2];
        cp_loaded_next = 1'b1;
        cp_next = cp_reg;
        if (!cp_loaded_reg)
            cp_next = ~I_CFG_CODE_PROTECT_N;
        // only bulk erase releases the lock
        else if (bulk_edge)
            cp_next = 1'b0;
        pgm_rd_next = pgm_sync[0] & ~cp_reg;
        pgm_wr_next = pgm_sync[1] & ~cp_reg;
    end

    // Locked is the safe value until the strap is read
    always_ff @(posedge I_CLOCK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cp_reg <= 1'b1;
            cp_loaded_reg <= 1'b0;
            bulk_prev_reg <= 1'b0;
            pgm_rd_reg <= 1'b0;
            pgm_wr_reg <= 1'b0;
        end
        else
        begin
            cp_reg <= cp_next;
            cp_loaded_reg <= cp_loaded_next;
            bulk_prev_reg <= bulk_prev_next;
            pgm_rd_reg <= pgm_rd_next;
            pgm_wr_reg <= pgm_wr_next;
        end
    end

    // Outputs straight from flip-flops
    assign O_REG_RDATA = rdata_reg;
    assign O_IND_RDATA = ind_rdata_reg;
    assign O_IND_VALID = ind_valid_reg;
    assign O_IND_STALL = stall_reg;
    assign O_FLASH_CMD = flash_reg;
    assign O_PGM_RD_GRANT = pgm_rd_reg;
    assign O_PGM_WR_GRANT = pgm_wr_reg;
    assign O_CODE_LOCKED = cp_reg;
    assign O_WP_REFUSED = refused_reg;
    assign O_BUSY = busy_reg;

endmodule

`default_nettype wire

// [pfsa_assertions.sv]
// Port-level concurrent checks for the flash access block
`timescale 1ns/1ns
`default_nettype none
`include "pfsa_map.svh"

module pfsa_assertions
    import pfsa_pkg::*;
(
    input wire logic I_CLOCK,
    input wire logic I_ARST_N,
    input wire logic I_POR_N,
    input wire logic [15:0] I_IND_ADDR,
    input wire logic O_IND_VALID,
    input wire logic O_IND_STALL,
    input wire pfsa_flash_cmd_type O_FLASH_CMD,
    input wire logic [1:0] I_CFG_WRITE_PROTECT,
    input wire logic O_PGM_RD_GRANT,
    input wire logic O_PGM_WR_GRANT,
    input wire logic O_CODE_LOCKED,
    input wire logic O_WP_REFUSED,
    input wire logic O_BUSY
);
    logic rst_n;
    logic [7:0] erase_cnt_reg;

    // ********************
    // Helper logic
    // ********************
    // Either reset clears the block, so either one silences the checks
    assign rst_n = I_ARST_N & I_POR_N;

    // Length of the current erase pulse; too long for a repetition
    always_ff @(posedge I_CLOCK or negedge rst_n)
    begin
        if (!rst_n)
            erase_cnt_reg <= 8'h00;
        else if (O_FLASH_CMD.erase)
            erase_cnt_reg <= erase_cnt_reg + 8'h01;
        else
            erase_cnt_reg <= 8'h00;
    end

    default clocking cb @(posedge I_CLOCK);
    endclocking
    default disable iff (!rst_n);

    // ********************
    // Properties
    // ********************
    property p_erase_len;
        $fell(O_FLASH_CMD.erase) |-> erase_cnt_reg == `PFSA_ERASE_CYCLES;
    endproperty
    a_erase_len: assert property (p_erase_len)
        else $error("erase pulse length wrong");

    property p_erase_row;
        O_FLASH_CMD.erase |-> O_FLASH_CMD.addr[4:0] == 5'h00;
    endproperty
    a_erase_row: assert property (p_erase_row)
        else $error("erase address not a row base");

    property p_wp_all;
        $rose(O_FLASH_CMD.erase || O_FLASH_CMD.prog)
            |-> I_CFG_WRITE_PROTECT != 2'h0;
    endproperty
    a_wp_all: assert property (p_wp_all)
        else $error("flash altered while fully protected");

    property p_wp_pulse;
        O_WP_REFUSED |-> (I_CFG_WRITE_PROTECT != 2'h3) ##1 !O_WP_REFUSED;
    endproperty
    a_wp_pulse: assert property (p_wp_pulse)
        else $error("protection refusal pulse wrong");

    property p_lock_grant;
        O_CODE_LOCKED |-> !O_PGM_RD_GRANT && !O_PGM_WR_GRANT;
    endproperty
    a_lock_grant: assert property (p_lock_grant)
        else $error("programmer granted while locked");

    property p_bulk_unlock;
        $rose(O_FLASH_CMD.bulk) |-> ##[0:2] !O_CODE_LOCKED;
    endproperty
    a_bulk_unlock: assert property (p_bulk_unlock)
        else $error("bulk erase left the lock set");

    property p_ind_timing;
        $rose(O_IND_STALL)
            |-> O_IND_STALL [*2] ##1 (!O_IND_STALL && O_IND_VALID);
    endproperty
    a_ind_timing: assert property (p_ind_timing)
        else $error("indirect read timing wrong");

    property p_ind_top;
        $rose(O_IND_STALL) |-> $past(I_IND_ADDR[15]);
    endproperty
    a_ind_top: assert property (p_ind_top)
        else $error("indirect read taken without top bit");

    property p_ind_addr;
        O_IND_STALL && O_FLASH_CMD.rd
            |-> O_FLASH_CMD.addr == I_IND_ADDR[14:0];
    endproperty
    a_ind_addr: assert property (p_ind_addr)
        else $error("indirect read address wrong");

    property p_cmd_busy;
        O_FLASH_CMD.erase || O_FLASH_CMD.prog |-> O_BUSY;
    endproperty
    a_cmd_busy: assert property (p_cmd_busy)
        else $error("flash operation while not busy");

    // Main scenarios reached
    c_erase: cover property ($fell(O_FLASH_CMD.erase));
    c_ind: cover property (O_IND_VALID);
    c_wp: cover property (O_WP_REFUSED);
    c_bulk: cover property ($rose(O_FLASH_CMD.bulk));
endmodule

bind pfsa_top pfsa_assertions i_chk (.*);

`default_nettype wire

// [tb.sv]
// Self-checking bench for the flash access block
`timescale 1ns/1ns
`default_nettype none
`include "pfsa_map.svh"

module tb
    import pfsa_pkg::*;
();
    logic clk, arst_n, por_n, reg_wr, ind_rd, cp_n;
    logic pgm_rd, pgm_wr, pgm_bulk, ind_valid, ind_stall;
    logic rd_grant, wr_grant, locked, wp_ref, busy;
    logic [2:0] reg_sel;
    logic [7:0] reg_wdata, reg_rdata, ind_rdata;
    logic [15:0] ind_addr;
    logic [13:0] flash_rdata, w, ld_w;
    logic [14:0] rd_addr, er_addr;
    logic [1:0] wp;
    pfsa_flash_cmd_type cmd;
    int mismatches, samples_checked, erase_len, wp_seen, n, st, e0, r0;

    pfsa_top i_dut (.I_CLOCK(clk), .I_ARST_N(arst_n), .I_POR_N(por_n),
        .I_REG_WR(reg_wr), .I_REG_SEL(reg_sel), .I_REG_WDATA(reg_wdata),
        .O_REG_RDATA(reg_rdata), .I_IND_RD(ind_rd), .I_IND_ADDR(ind_addr),
        .O_IND_RDATA(ind_rdata), .O_IND_VALID(ind_valid),
        .O_IND_STALL(ind_stall), .O_FLASH_CMD(cmd),
        .I_FLASH_RDATA(flash_rdata), .I_CFG_CODE_PROTECT_N(cp_n),
        .I_CFG_WRITE_PROTECT(wp), .I_PGM_RD_REQ(pgm_rd),
        .I_PGM_WR_REQ(pgm_wr), .I_PGM_BULK_ERASE(pgm_bulk),
        .O_PGM_RD_GRANT(rd_grant), .O_PGM_WR_GRANT(wr_grant),
        .O_CODE_LOCKED(locked), .O_WP_REFUSED(wp_ref), .O_BUSY(busy));

    // Flash word per address, distinct within the low 14 address bits
    function automatic logic [13:0] fword(input logic [14:0] a);
        return a[13:0] ^ 14'h2A5A;
    endfunction

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Flash array stand-in and traffic monitors
    always @(posedge clk)
    begin
        flash_rdata <= fword(cmd.addr);
        if (cmd.rd) rd_addr <= cmd.addr;
        if (cmd.erase) er_addr <= cmd.addr;
        if (cmd.erase | cmd.prog) erase_len <= erase_len + 1;
        if (cmd.load && cmd.addr[4:0] == 5'h0B) ld_w <= cmd.wdata;
        if (wp_ref) wp_seen <= wp_seen + 1;
    end

    // ********************
    // Tasks
    // ********************
    task automatic test_done();
        if (mismatches == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp)
        begin
            mismatches = mismatches + 1;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // One write; the strobe drops at the next edge
    task automatic wr(input logic [2:0] s, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_sel <= s;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // Registered readback: sampled two edges after select
    task automatic rchk(input logic [2:0] s, input logic [7:0] m,
                        input logic [7:0] exp);
        @(posedge clk);
        reg_sel <= s;
        repeat (2) @(posedge clk);
        chk(16'(reg_rdata & m), 16'(exp));
    endtask

    task automatic unlock_go(input logic [7:0] ctl);
        wr(`PFSA_SEL_UNLOCK, 8'h55);
        wr(`PFSA_SEL_UNLOCK, 8'hAA);
        wr(`PFSA_SEL_CONTROL, ctl);
    endtask

    // Busy rises one cycle after the start write lands
    task automatic wait_idle();
        n = 0;
        repeat (3) @(posedge clk);
        while (busy !== 1'b0 && n < 200)
        begin
            @(posedge clk);
            n = n + 1;
        end
        if (n >= 200)
        begin
            mismatches = mismatches + 1;
            test_done();
        end
    endtask

    // ********************
    // Main sequence
    // ********************
    initial
    begin
        {arst_n, por_n, reg_wr, ind_rd, cp_n} = 5'h00;
        {pgm_rd, pgm_wr, pgm_bulk} = 3'h0;
        reg_sel = 3'h0;
        reg_wdata = 8'h00;
        ind_addr = 16'h0000;
        wp = 2'h3;
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        por_n <= 1'b1;
        repeat (3) @(posedge clk);
        chk(16'(locked), 16'h0001);
        rchk(`PFSA_SEL_CONTROL, 8'hFF, 8'h00);
        wr(`PFSA_SEL_UNLOCK, 8'h55);
        rchk(`PFSA_SEL_UNLOCK, 8'hFF, 8'h00);
        // Read at the last word of the address space
        wr(`PFSA_SEL_ADDR_HIGH, 8'hFF);
        wr(`PFSA_SEL_ADDR_LOW, 8'hFF);
        wr(`PFSA_SEL_CONTROL, 8'h01);
        wait_idle();
        w = fword(15'h7FFF);
        chk(16'(rd_addr), 16'h7FFF);
        rchk(`PFSA_SEL_DATA_LOW, 8'hFF, w[7:0]);
        rchk(`PFSA_SEL_DATA_HIGH, 8'h3F, 8'(w[13:8]));
        rchk(`PFSA_SEL_CONTROL, 8'h01, 8'h00);
        // Start without keys, interrupted key sequence, and without write enable
        wr(`PFSA_SEL_CONTROL, 8'h06);
        rchk(`PFSA_SEL_CONTROL, 8'h06, 8'h04);
        wr(`PFSA_SEL_UNLOCK, 8'h55);
        wr(`PFSA_SEL_ADDR_LOW, 8'h2B);
        wr(`PFSA_SEL_UNLOCK, 8'hAA);
        wr(`PFSA_SEL_CONTROL, 8'h06);
        rchk(`PFSA_SEL_CONTROL, 8'h02, 8'h00);
        unlock_go(8'h02);
        rchk(`PFSA_SEL_CONTROL, 8'h02, 8'h00);
        // Erase at 0x032B under every protection code, lock still set
        wr(`PFSA_SEL_ADDR_HIGH, 8'h03);
        for (int k = 0; k < 4; k++)
        begin
            @(posedge clk);
            wp <= 2'(k);
            e0 = erase_len;
            r0 = wp_seen;
            unlock_go(8'h16);
            wait_idle();
            chk(16'(wp_seen - r0), (k < 2) ? 16'h0001 : 16'h0000);
            chk(16'(erase_len - e0), (k < 2) ? 16'h0000 : 16'h0028);
        end
        chk(16'(er_addr), 16'h0320);
        // Software cannot stop an erase once started
        e0 = erase_len;
        unlock_go(8'h16);
        wr(`PFSA_SEL_CONTROL, 8'h14);
        rchk(`PFSA_SEL_CONTROL, 8'h02, 8'h02);
        wait_idle();
        chk(16'(erase_len - e0), 16'h0028);
        rchk(`PFSA_SEL_CONTROL, 8'h02, 8'h00);
        // One latch loaded, then the row programmed
        wr(`PFSA_SEL_DATA_LOW, 8'h3C);
        wr(`PFSA_SEL_DATA_HIGH, 8'h15);
        unlock_go(8'h26);
        e0 = erase_len;
        unlock_go(8'h06);
        wait_idle();
        chk(16'(erase_len - e0), 16'h0028);
        chk(16'(ld_w), 16'h153C);
        // Indirect read through the pointer path
        @(posedge clk);
        ind_addr <= 16'h8123;
        ind_rd <= 1'b1;
        {n, st} = 64'h0;
        do
        begin
            @(posedge clk);
            #1;
            n = n + 1;
            if (ind_stall === 1'b1) st = st + 1;
        end while (ind_valid !== 1'b1 && n < 20);
        ind_rd <= 1'b0;
        w = fword(15'h0123);
        chk(16'(n), 16'h0003);
        chk(16'(st), 16'h0002);
        chk({8'h00, ind_rdata}, {8'h00, w[7:0]});
        chk(16'(rd_addr), 16'h0123);
        // Pointer without the top bit never reaches flash
        @(posedge clk);
        ind_addr <= 16'h0123;
        ind_rd <= 1'b1;
        st = 0;
        repeat (8)
        begin
            @(posedge clk);
            if (ind_stall !== 1'b0) st = st + 1;
        end
        ind_rd <= 1'b0;
        chk(16'(st), 16'h0000);
        // Reset landing in mid-erase leaves the error flag
        unlock_go(8'h16);
        repeat (10) @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        chk(16'(cmd.erase), 16'h0000);
        rchk(`PFSA_SEL_CONTROL, 8'h08, 8'h08);
        // Programmer blocked until bulk erase
        pgm_rd <= 1'b1;
        pgm_wr <= 1'b1;
        repeat (6) @(posedge clk);
        chk(16'({rd_grant, wr_grant, locked}), 16'h0001);
        pgm_bulk <= 1'b1;
        repeat (6) @(posedge clk);
        chk(16'({rd_grant, wr_grant, locked}), 16'h0006);
        pgm_bulk <= 1'b0;
        repeat (4) @(posedge clk);
        test_done();
    end
endmodule

`default_nettype wire
